// ===== rtl/ubdd_engine.sv
`timescale 1ns/1ps
// Behaviour
// - Control word holds ten-bit byte count at 25:16; other high bits reserved.
// - After a receive, byte count is rewritten with bytes actually written to the buffer.
// - Ownership bit 7: one gives engine exclusive use, zero the processor.
// - After a token, ownership is cleared unless retain or halt bit is set or a device latency overrun occurs.
// - Unowned descriptor: every other field is ignored.
// - Bit 6 selects DATA0 or DATA1 and is never modified.
// - Retain bit keeps ownership and skips writeback; done notice only on host latency overrun.
// - Fixed-address bit stops buffer address increment.
// - Toggle-check bit enables data toggle synchronisation.
// - Halt bit answers STALL and leaves the descriptor untouched.
// - Without retain, device mode puts token PID into bits 5:2 at completion.
// - Host mode writes back returned PID or status code.
// - Control bits 1:0 read as zero.
// - Second word is the buffer pointer, never modified.
// - Fetch indexed descriptor per token; move data only when owned.
// - Completion writes back, updates status, sets done flag.
// - Latency overflow: NAK or timeout, set overrun, interrupt if enabled.
// - Device latency overrun: no writeback, no done flag.
// - Host latency overrun: done flag and PID all ones.
// - Oversized packet: keep ACK, clip, overrun and done, count=limit.
// - Descriptor address is page, endpoint, direction and odd bit.
module ubdd_engine
	import ubdd_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        SRST_IN,
	// Register port
	input  wire logic [7:0]  REG_ADDR_IN,
	input  wire logic [31:0] REG_WDATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	output logic      [31:0] REG_RDATA_OUT,
	output logic             IRQ_OUT,
	// Token from serial engine
	input  wire logic        TOK_VALID_IN,
	input  wire logic [3:0]  TOKEN_PID_WRITEBACK_IN,
	input  wire logic [3:0]  TOK_EP_IN,
	input  wire logic        TOK_TX_IN,
	input  wire logic        TOK_ODD_IN,
	input  wire logic        TOK_ISO_IN,
	input  wire logic [3:0]  SIE_RESULT_IN,
	output logic             TOK_READY_OUT,
	// Handshake and toggle to serial engine
	output logic             HS_VALID_OUT,
	output logic      [1:0]  HS_CODE_OUT,
	output logic             TOGGLE_CHECK_OUT,
	output logic             DATA1_OUT,
	// Receive stream
	input  wire logic        RX_VALID_IN,
	input  wire logic [7:0]  RX_DATA_IN,
	input  wire logic        RX_END_IN,
	input  wire logic        RX_LATE_IN,
	output logic             RX_READY_OUT,
	// Transmit stream
	output logic             TX_VALID_OUT,
	output logic      [7:0]  TX_DATA_OUT,
	input  wire logic        TX_READY_IN,
	// Memory master
	output logic             MEM_REQ_OUT,
	output logic             MEM_WE_OUT,
	output logic             MEM_WORD_OUT,
	output logic      [31:0] MEM_ADDR_OUT,
	output logic      [31:0] MEM_WDATA_OUT,
	input  wire logic        MEM_ACK_IN,
	input  wire logic [31:0] MEM_RDATA_IN
);
	import ubdd_pkg::*;

	ubdd_state_t state;
	ubdd_state_t next_state;
	logic [31:0] page;
	logic        host_mode;
	logic [7:0]  imask;
	logic [7:0]  emask;
	logic [7:0]  stat;
	logic [3:0]  token_pid_writeback;
	logic        tok_tx;
	logic        tok_iso;
	logic [31:0] desc_addr;
	logic [31:0] ctrl;
	logic [31:0] ptr;
	logic [BC_W-1:0] cnt;
	logic        pend;
	logic [7:0]  hold;
	logic        ovf;
	logic        late;
	logic        rx_end;
	logic [3:0]  wb_pid;
	logic        flag_done;
	logic        flag_ovr;

	////////////////////////////////////////////////////////////////////
	// Decode
	wire is_idle   = (state == ST_IDLE);
	wire is_fetchc = (state == ST_FETCHC);
	wire is_fetcha = (state == ST_FETCHA);
	wire is_move   = (state == ST_MOVE);
	wire is_finish = (state == ST_FINISH);
	wire is_wback  = (state == ST_WBACK);
	wire [BC_W-1:0] bc = ctrl[BC_MSB:BC_LSB];
	wire own   = MEM_RDATA_IN[OWN_BIT];
	wire halt  = MEM_RDATA_IN[HALT_BIT];
	wire keep  = ctrl[KEEP_BIT];
	wire fixed_address_flag  = ctrl[FIXED_ADDRESS_FLAG_BIT];
	wire take  = is_idle & TOK_VALID_IN;
	wire ack   = MEM_ACK_IN & MEM_REQ_OUT;
	wire tx_rq = is_move & tok_tx & ~pend & (cnt != bc);
	wire rx_wr = is_move & ~tok_tx & pend;
	wire rx_in = RX_VALID_IN & RX_READY_OUT;
	wire [31:0] step = fixed_address_flag ? 32'h0 : 32'h1;
	wire [BC_W-1:0] bc_new = tok_tx ? bc : cnt;
	wire [31:0] ctrl_new = {RSV_HI, bc_new, RSV_MID, 1'b0,
		ctrl[PAR_BIT], wb_pid, RSV_LO};
	wire [31:0] entry = {page[31:PAGE_LSB], TOK_EP_IN, TOK_TX_IN,
		TOK_ODD_IN, ENTRY_LO};
	wire move_end = tok_tx ? (~pend & (cnt == bc))
		: (late | (rx_end & ~pend));
	wire [3:0] pid_done = host_mode ? SIE_RESULT_IN : token_pid_writeback;
	wire set_done = (is_wback & ack) | (is_wback & late & keep);
	wire set_ovr  = is_finish & (late | ovf);
	wire reg_wr_flags = REG_WR_IN & (REG_ADDR_IN == REG_FLAGS);

	assign TOK_READY_OUT = is_idle;
	assign RX_READY_OUT  = is_move & ~tok_tx & ~pend & ~late;
	assign TX_VALID_OUT  = is_move & tok_tx & pend;
	assign MEM_REQ_OUT   = is_fetchc | is_fetcha | tx_rq | rx_wr
		| (is_wback & ~keep);
	assign MEM_WE_OUT    = rx_wr | is_wback;
	assign MEM_WORD_OUT  = is_fetchc | is_fetcha | is_wback;
	assign MEM_ADDR_OUT  = is_fetchc ? desc_addr
		: is_fetcha ? desc_addr + PTR_OFS
		: is_wback ? desc_addr : ptr;
	assign MEM_WDATA_OUT = is_wback ? ctrl_new : {24'h0, hold};
	assign IRQ_OUT = (flag_done & imask[IEN_DONE])
		| (flag_ovr & imask[IEN_ERR] & emask[EEN_DMA]);

	////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (TOK_VALID_IN)
					next_state = ST_FETCHC;
			end
			ST_FETCHC: begin
				if (ack) begin
					// Halt is only honoured on an owned entry
					if (!own || halt)
						next_state = ST_IDLE;
					else
						next_state = ST_FETCHA;
				end
			end
			ST_FETCHA: begin
				if (ack)
					next_state = ST_MOVE;
			end
			ST_MOVE: begin
				if (move_end)
					next_state = ST_FINISH;
			end
			ST_FINISH: begin
				if (late && !host_mode)
					next_state = ST_IDLE;
				else
					next_state = ST_WBACK;
			end
			ST_WBACK: begin
				if (keep || ack)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////
	// Token and descriptor capture
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			token_pid_writeback   <= PID_OUT;
			tok_tx    <= 1'b0;
			tok_iso   <= 1'b0;
			desc_addr <= 32'h0;
			ctrl      <= 32'h0;
		end else if (take) begin
			token_pid_writeback   <= TOKEN_PID_WRITEBACK_IN;
			tok_tx    <= TOK_TX_IN;
			tok_iso   <= TOK_ISO_IN;
			desc_addr <= entry;
		end else if (is_fetchc && ack) begin
			ctrl <= MEM_RDATA_IN;
		end
	end

	assign TOGGLE_CHECK_OUT = ctrl[DTS_BIT];
	assign DATA1_OUT        = ctrl[PAR_BIT];

	////////////////////////////////////////////////////////////////////
	// Data mover
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			ptr    <= 32'h0;
			cnt    <= '0;
			pend   <= 1'b0;
			hold   <= 8'h00;
			ovf    <= 1'b0;
			late   <= 1'b0;
			rx_end <= 1'b0;
		end else if (is_fetcha) begin
			ptr    <= MEM_RDATA_IN;
			cnt    <= '0;
			pend   <= 1'b0;
			ovf    <= 1'b0;
			late   <= 1'b0;
			rx_end <= 1'b0;
		end else if (is_move) begin
			if (RX_END_IN && !tok_tx)
				rx_end <= 1'b1;
			if (RX_LATE_IN && !tok_tx)
				late <= 1'b1;
			if (tx_rq && ack) begin
				hold <= MEM_RDATA_IN[7:0];
				pend <= 1'b1;
				cnt  <= cnt + 1'b1;
				ptr  <= ptr + step;
			end else if (TX_VALID_OUT && TX_READY_IN) begin
				pend <= 1'b0;
			end else if (rx_wr && ack) begin
				pend <= 1'b0;
				cnt  <= cnt + 1'b1;
				ptr  <= ptr + step;
			end else if (rx_in) begin
				// Excess bytes are dropped so memory past the
				// buffer is never touched
				if (cnt == bc)
					ovf <= 1'b1;
				else begin
					hold <= RX_DATA_IN;
					pend <= 1'b1;
				end
			end
		end
	end

	assign TX_DATA_OUT = hold;

	////////////////////////////////////////////////////////////////////
	// Handshake and writeback PID
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			HS_VALID_OUT <= 1'b0;
			HS_CODE_OUT  <= HS_TMO;
			wb_pid       <= PID_TMO;
		end else begin
			HS_VALID_OUT <= 1'b0;
			if (is_fetchc && ack && !own && !host_mode) begin
				HS_VALID_OUT <= 1'b1;
				HS_CODE_OUT  <= HS_NAK;
			end else if (is_fetchc && ack && own && halt) begin
				HS_VALID_OUT <= 1'b1;
				HS_CODE_OUT  <= HS_STALL;
			end else if (is_finish && late) begin
				HS_VALID_OUT <= 1'b1;
				HS_CODE_OUT  <= host_mode ? HS_TMO : HS_NAK;
				wb_pid       <= PID_LATE;
			end else if (is_finish) begin
				// Isochronous traffic carries no handshake
				HS_VALID_OUT <= ~tok_tx & ~tok_iso;
				HS_CODE_OUT  <= HS_ACK;
				wb_pid       <= pid_done;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Registers
	ubdd_flag u_done (
		.clk_in  (CLK_IN),
		.srst_in (SRST_IN),
		.set_in  (set_done),
		.clr_in  (reg_wr_flags & REG_WDATA_IN[FLG_DONE]),
		.q_out   (flag_done)
	);

	ubdd_flag u_ovr (
		.clk_in  (CLK_IN),
		.srst_in (SRST_IN),
		.set_in  (set_ovr),
		.clr_in  (reg_wr_flags & REG_WDATA_IN[FLG_OVR]),
		.q_out   (flag_ovr)
	);

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			host_mode <= 1'b0;
			page      <= 32'h0;
			imask     <= 8'h00;
			emask     <= 8'h00;
			stat      <= 8'h00;
		end else begin
			if (REG_WR_IN && REG_ADDR_IN == REG_CTRL)
				host_mode <= REG_WDATA_IN[CTL_HOST];
			if (REG_WR_IN && REG_ADDR_IN == REG_PAGE)
				page <= {REG_WDATA_IN[31:PAGE_LSB], 9'h000};
			if (REG_WR_IN && REG_ADDR_IN == REG_IMASK)
				imask <= REG_WDATA_IN[7:0];
			if (REG_WR_IN && REG_ADDR_IN == REG_EMASK)
				emask <= REG_WDATA_IN[7:0];
			if (set_done)
				stat <= desc_addr[PAGE_LSB-1:1];
		end
	end

	wire [31:0] rd_mux =
		(REG_ADDR_IN == REG_CTRL)  ? {31'h0, host_mode} :
		(REG_ADDR_IN == REG_PAGE)  ? page :
		(REG_ADDR_IN == REG_STAT)  ? {24'h0, stat} :
		(REG_ADDR_IN == REG_FLAGS) ? {30'h0, flag_ovr, flag_done} :
		(REG_ADDR_IN == REG_IMASK) ? {24'h0, imask} :
		(REG_ADDR_IN == REG_EMASK) ? {24'h0, emask} : 32'h0;

	// Read data stands for the one cycle after the strobe only
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN)
			REG_RDATA_OUT <= 32'h0;
		else
			REG_RDATA_OUT <= REG_RD_IN ? rd_mux : 32'h0;
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);

	a_unowned_ignored: assert property (
		is_fetchc && ack && !own |=> is_idle && !MEM_REQ_OUT)
		else $error("unowned descriptor used");
	a_halt_stall: assert property (
		is_fetchc && ack && own && halt
		|=> HS_VALID_OUT && HS_CODE_OUT == HS_STALL && is_idle)
		else $error("halt without stall");
	a_device_nak: assert property (
		is_fetchc && ack && !own && !host_mode
		|=> HS_VALID_OUT && HS_CODE_OUT == HS_NAK)
		else $error("unowned token not refused");
	a_fixed_addr: assert property (
		is_move && fixed_address_flag |=> $stable(ptr))
		else $error("fixed address moved");
	a_wb_format: assert property (
		is_wback && MEM_REQ_OUT |-> !MEM_WDATA_OUT[OWN_BIT]
		&& MEM_WDATA_OUT[PAR_BIT] == ctrl[PAR_BIT]
		&& MEM_WDATA_OUT[1:0] == RSV_LO)
		else $error("bad writeback word");
	a_keep_silent: assert property (
		is_wback && keep && !late |-> !MEM_REQ_OUT ##1
		(is_idle && !$rose(flag_done)))
		else $error("retained descriptor written");
	a_done_after_wb: assert property (
		is_wback && ack |=> flag_done)
		else $error("done flag missing");
	a_dev_late_quiet: assert property (
		is_finish && late && !host_mode |=> is_idle ##1 !flag_done
		or $past(flag_done, 2))
		else $error("device overrun wrote back");
	a_host_late_pid: assert property (
		is_wback && late && MEM_REQ_OUT
		|-> MEM_WDATA_OUT[5:2] == PID_LATE)
		else $error("latency pid wrong");
	a_rx_clip: assert property (
		is_move && !tok_tx |-> cnt <= bc)
		else $error("receive past limit");
	a_ptr_kept: assert property (
		MEM_WE_OUT && MEM_WORD_OUT |-> MEM_ADDR_OUT == desc_addr)
		else $error("pointer word written");

	c_tx_done: cover property (is_wback && ack && tok_tx);
	c_rx_clip: cover property (is_finish && ovf);
	c_late: cover property (is_finish && late);
	c_stall: cover property (HS_VALID_OUT && HS_CODE_OUT == HS_STALL);
endmodule // ubdd_engine

// ===== rtl/ubdd_pkg.sv
package ubdd_pkg;
	// Descriptor control word layout
	localparam int BC_LSB   = 16;
	localparam int BC_MSB   = 25;
	localparam int OWN_BIT  = 7;
	localparam int PAR_BIT  = 6;
	localparam int KEEP_BIT = 5;
	localparam int FIXED_ADDRESS_FLAG_BIT = 4;
	localparam int DTS_BIT  = 3;
	localparam int HALT_BIT = 2;
	localparam int PID_LSB  = 2;
	localparam int BC_W     = 10;
	localparam int PAGE_LSB = 9;
	localparam logic [31:0] PTR_OFS = 32'h0000_0004;
	localparam logic [5:0]  RSV_HI  = 6'h00;
	localparam logic [7:0]  RSV_MID = 8'h00;
	localparam logic [1:0]  RSV_LO  = 2'h0;
	localparam logic [2:0]  ENTRY_LO = 3'h0;
	// Token PIDs and host status codes
	localparam logic [3:0] PID_OUT   = 4'h1;
	localparam logic [3:0] PID_IN    = 4'h9;
	localparam logic [3:0] PID_SETUP = 4'hD;
	localparam logic [3:0] PID_DATA0 = 4'h3;
	localparam logic [3:0] PID_DATA1 = 4'hB;
	localparam logic [3:0] PID_ACK   = 4'h2;
	localparam logic [3:0] PID_STALL = 4'hE;
	localparam logic [3:0] PID_NAK   = 4'hA;
	localparam logic [3:0] PID_TMO   = 4'h0;
	localparam logic [3:0] PID_DERR  = 4'hF;
	localparam logic [3:0] PID_LATE  = 4'hF;
	// Handshake codes towards the serial engine
	localparam logic [1:0] HS_TMO   = 2'h0;
	localparam logic [1:0] HS_ACK   = 2'h1;
	localparam logic [1:0] HS_NAK   = 2'h2;
	localparam logic [1:0] HS_STALL = 2'h3;
	// Register map
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_PAGE  = 8'h04;
	localparam logic [7:0] REG_STAT  = 8'h08;
	localparam logic [7:0] REG_FLAGS = 8'h0C;
	localparam logic [7:0] REG_IMASK = 8'h10;
	localparam logic [7:0] REG_EMASK = 8'h14;
	localparam int FLG_DONE = 0;
	localparam int FLG_OVR  = 1;
	localparam int IEN_DONE = 0;
	localparam int IEN_ERR  = 1;
	localparam int EEN_DMA  = 0;
	localparam int CTL_HOST = 0;
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_FETCHC = 6'h02,
		ST_FETCHA = 6'h04,
		ST_MOVE   = 6'h08,
		ST_FINISH = 6'h10,
		ST_WBACK  = 6'h20
	} ubdd_state_t;
endpackage

// ===== rtl/ubdd_flag.sv
`timescale 1ns/1ps
module ubdd_flag (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic srst_in,
	// Event and clear
	input  wire logic set_in,
	input  wire logic clr_in,
	output logic      q_out
);
	// A set in the clear cycle wins so no event is lost
	always_ff @(posedge clk_in) begin
		if (srst_in)
			q_out <= 1'b0;
		else
			q_out <= set_in | (q_out & ~clr_in);
	end

	a_set_wins: assert property (@(posedge clk_in) disable iff (srst_in)
		set_in |=> q_out)
		else $error("flag set lost");
endmodule // ubdd_flag

// ===== verification/ubdd_mem_model.sv
`timescale 1ns/1ps
module ubdd_mem_model (
	// Clock
	input  wire logic        clk_in,
	// Memory slave side
	input  wire logic        req_in,
	input  wire logic        we_in,
	input  wire logic        word_in,
	input  wire logic [31:0] addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic [3:0]  delay_in,
	output logic             ack_out,
	output logic      [31:0] rdata_out,
	output int               wr_cnt_out
);
	logic [7:0]  mem [0:16383];
	logic [3:0]  wait_cnt;
	logic [13:0] a;

	assign a = addr_in[13:0];
	initial begin
		ack_out = 1'b0;
		rdata_out = 32'h0;
		wait_cnt = 4'h0;
		wr_cnt_out = 0;
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	// Read data toggle outside an answer so a stale word never looks valid
	always @(posedge clk_in) begin
		ack_out <= 1'b0;
		rdata_out <= ~rdata_out;
		if (req_in && !ack_out && wait_cnt < delay_in)
			wait_cnt <= wait_cnt + 4'h1;
		else if (req_in && !ack_out) begin
			wait_cnt <= 4'h0;
			ack_out <= 1'b1;
			if (we_in) begin
				wr_cnt_out <= wr_cnt_out + 1;
				for (int i = 0; i < (word_in ? 4 : 1); i++)
					mem[a + 14'(i)] <= wdata_in[8*i +: 8];
			end else
				for (int i = 0; i < 4; i++)
					rdata_out[8*i +: 8] <= (word_in || i == 0) ?
						mem[a + 14'(i)] : 8'h00;
		end
	end
endmodule // ubdd_mem_model

// ===== verification/usb_buffer_descriptor_dma_tb.sv
`timescale 1ns/1ps
module usb_buffer_descriptor_dma_tb;
	import ubdd_pkg::*;
	localparam logic [31:0] PAGE = 32'h0000_2000;
	localparam logic [31:0] BUF  = 32'h0000_1000;
	logic        CLK_IN, SRST_IN, REG_WR_IN, REG_RD_IN, IRQ_OUT;
	logic [7:0]  REG_ADDR_IN, RX_DATA_IN, TX_DATA_OUT;
	logic [31:0] REG_WDATA_IN, REG_RDATA_OUT, MEM_ADDR_OUT, MEM_WDATA_OUT;
	logic        TOK_VALID_IN, TOK_TX_IN, TOK_ODD_IN, TOK_READY_OUT;
	logic        TOK_ISO_IN, iso;
	logic [3:0]  TOKEN_PID_WRITEBACK_IN, TOK_EP_IN, SIE_RESULT_IN, mem_dly;
	logic        HS_VALID_OUT, TOGGLE_CHECK_OUT, DATA1_OUT, RX_VALID_IN;
	logic        RX_END_IN, RX_LATE_IN, RX_READY_OUT, TX_VALID_OUT;
	logic        TX_READY_IN, MEM_REQ_OUT, MEM_WE_OUT, MEM_WORD_OUT, MEM_ACK_IN;
	logic [1:0]  HS_CODE_OUT, hs_code;
	logic [31:0] MEM_RDATA_IN, da, d, c;
	logic [7:0]  txq [$];
	int          errors, n_checks, wr_cnt, w;

	ubdd_engine ubdd_engine_i (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
		.REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
		.REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
		.REG_RDATA_OUT(REG_RDATA_OUT), .IRQ_OUT(IRQ_OUT),
		.TOK_VALID_IN(TOK_VALID_IN), .TOKEN_PID_WRITEBACK_IN(TOKEN_PID_WRITEBACK_IN),
		.TOK_EP_IN(TOK_EP_IN), .TOK_TX_IN(TOK_TX_IN), .TOK_ODD_IN(TOK_ODD_IN),
		.TOK_ISO_IN(TOK_ISO_IN), .SIE_RESULT_IN(SIE_RESULT_IN),
		.TOK_READY_OUT(TOK_READY_OUT), .HS_VALID_OUT(HS_VALID_OUT),
		.HS_CODE_OUT(HS_CODE_OUT), .TOGGLE_CHECK_OUT(TOGGLE_CHECK_OUT),
		.DATA1_OUT(DATA1_OUT), .RX_VALID_IN(RX_VALID_IN),
		.RX_DATA_IN(RX_DATA_IN), .RX_END_IN(RX_END_IN),
		.RX_LATE_IN(RX_LATE_IN), .RX_READY_OUT(RX_READY_OUT),
		.TX_VALID_OUT(TX_VALID_OUT), .TX_DATA_OUT(TX_DATA_OUT),
		.TX_READY_IN(TX_READY_IN), .MEM_REQ_OUT(MEM_REQ_OUT),
		.MEM_WE_OUT(MEM_WE_OUT), .MEM_WORD_OUT(MEM_WORD_OUT),
		.MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_WDATA_OUT(MEM_WDATA_OUT),
		.MEM_ACK_IN(MEM_ACK_IN), .MEM_RDATA_IN(MEM_RDATA_IN));
	ubdd_mem_model ubdd_mem_model_i (.clk_in(CLK_IN), .req_in(MEM_REQ_OUT),
		.we_in(MEM_WE_OUT), .word_in(MEM_WORD_OUT), .addr_in(MEM_ADDR_OUT),
		.wdata_in(MEM_WDATA_OUT), .delay_in(mem_dly), .ack_out(MEM_ACK_IN),
		.rdata_out(MEM_RDATA_IN), .wr_cnt_out(wr_cnt));

	initial begin
		CLK_IN = 1'b0;
		forever #12.5 CLK_IN = ~CLK_IN;
	end
	// Far side stalls every other cycle on transmit
	always @(posedge CLK_IN) TX_READY_IN <= ~TX_READY_IN;
	always @(negedge CLK_IN) begin
		if (HS_VALID_OUT === 1'b1) hs_code = HS_CODE_OUT;
		if (TX_VALID_OUT === 1'b1 && TX_READY_IN === 1'b1)
			txq.push_back(TX_DATA_OUT);
	end
	initial begin
		repeat (20000) @(posedge CLK_IN);
		errors++;
		complete_run;
	end
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [63:0] g, e, input string m);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge CLK_IN);
		REG_WR_IN <= 1'b1;
		REG_ADDR_IN <= a;
		REG_WDATA_IN <= v;
		@(posedge CLK_IN);
		REG_WR_IN <= 1'b0;
	endtask
	task rreg(input logic [7:0] a);
		@(posedge CLK_IN);
		REG_RD_IN <= 1'b1;
		REG_ADDR_IN <= a;
		@(posedge CLK_IN);
		REG_RD_IN <= 1'b0;
		@(negedge CLK_IN);
		d = REG_RDATA_OUT;
	endtask
	function automatic logic [31:0] rdw(input logic [31:0] a);
		for (int i = 3; i >= 0; i--)
			rdw = {rdw[23:0], ubdd_mem_model_i.mem[a[13:0] + 14'(i)]};
	endfunction
	// Highest byte first, so the ownership byte lands last
	task wrw(input logic [31:0] a, v);
		for (int i = 3; i >= 0; i--)
			ubdd_mem_model_i.mem[a[13:0] + 14'(i)] = v[8*i +: 8];
	endtask
	task put(input logic [3:0] ep, input logic tx, odd, input logic [31:0] p,
		input logic [9:0] bc, input logic [7:0] lo);
		da = PAGE | {23'h0, ep, tx, odd, ENTRY_LO};
		c = {RSV_HI, bc, RSV_MID, lo};
		wrw(da + PTR_OFS, p);
		wrw(da, c);
		w = wr_cnt;
		txq.delete();
	endtask
	function automatic logic [31:0] wb(input logic [9:0] bc, input logic par,
		input logic [3:0] pid);
		return {RSV_HI, bc, RSV_MID, 1'b0, par, pid, RSV_LO};
	endfunction
	task token(input logic [3:0] pid, ep, input logic tx, odd, input int nrx,
		input logic late);
		int k;
		@(posedge CLK_IN);
		hs_code = 2'bxx;
		TOK_VALID_IN <= 1'b1;
		TOKEN_PID_WRITEBACK_IN <= pid;
		TOK_EP_IN <= ep;
		TOK_TX_IN <= tx;
		TOK_ODD_IN <= odd;
		TOK_ISO_IN <= iso;
		@(posedge CLK_IN);
		TOK_VALID_IN <= 1'b0;
		for (int i = 0; i < nrx + int'(late); i++) begin
			RX_VALID_IN <= !late;
			RX_DATA_IN <= 8'hA0 + 8'(i);
			k = 0;
			do begin @(negedge CLK_IN); k++; end
			while (RX_READY_OUT !== 1'b1 && k < 99);
			chk(k < 99, 1, "rx wait");
			@(posedge CLK_IN);
			RX_LATE_IN <= late;
		end
		RX_VALID_IN <= 1'b0;
		RX_END_IN <= (nrx > 0);
		@(posedge CLK_IN);
		RX_LATE_IN <= 1'b0;
		RX_END_IN <= 1'b0;
		k = 0;
		do begin @(negedge CLK_IN); k++; end
		while (TOK_READY_OUT !== 1'b1 && k < 999);
		chk(k < 999, 1, "idle wait");
		// A refusal pulses in the first idle cycle: let the monitor see it
		@(negedge CLK_IN);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{REG_WR_IN, REG_RD_IN, TOK_VALID_IN, TOK_TX_IN, TOK_ODD_IN} = 5'h00;
		TOK_ISO_IN = 1'b0;
		iso = 1'b0;
		{RX_VALID_IN, RX_END_IN, RX_LATE_IN, TX_READY_IN} = 4'h0;
		{REG_ADDR_IN, RX_DATA_IN, TOKEN_PID_WRITEBACK_IN, TOK_EP_IN} = 24'h0;
		{REG_WDATA_IN, SIE_RESULT_IN, mem_dly} = 40'h0;
		SRST_IN = 1'b1;
		repeat (2) @(posedge CLK_IN);
		SRST_IN <= 1'b0;
		rreg(REG_FLAGS);
		chk(d, 32'h0, "flags at reset");
		rreg(8'h3C);
		chk(d, 32'h0, "unmapped read");
		wreg(REG_PAGE, PAGE);
		wreg(REG_IMASK, 32'h3);
		wreg(REG_EMASK, 32'h1);
		put(4'h5, 1'b0, 1'b1, BUF, 10'h4, 8'hC8);
		token(PID_OUT, 4'h5, 1'b0, 1'b1, 2, 1'b0);
		chk(hs_code, HS_ACK, "out ack");
		chk(rdw(da), wb(2, 1, PID_OUT), "out wb");
		chk(rdw(da + PTR_OFS), BUF, "pointer kept");
		chk(rdw(BUF), 32'hA1A0, "rx data");
		chk({DATA1_OUT, TOGGLE_CHECK_OUT}, 2'h3, "par/toggle");
		rreg(REG_STAT);
		chk(d, 32'h54, "status");
		chk(IRQ_OUT, 1, "done irq");
		wreg(REG_FLAGS, 32'h1);
		rreg(REG_FLAGS);
		chk({IRQ_OUT, d}, 33'h0, "flag clear");
		$display("-- out done");
		put(4'h1, 1'b0, 1'b0, BUF, 10'h4, 8'h48);
		token(PID_OUT, 4'h1, 1'b0, 1'b0, 0, 1'b0);
		chk(hs_code, HS_NAK, "unowned nak");
		chk({rdw(da), wr_cnt}, {c, w}, "unowned untouched");
		put(4'h2, 1'b1, 1'b0, BUF, 10'h4, 8'h84);
		token(PID_IN, 4'h2, 1'b1, 1'b0, 0, 1'b0);
		chk(hs_code, HS_STALL, "stall");
		chk({rdw(da), wr_cnt}, {c, w}, "stall untouched");
		$display("-- refusal done");
		mem_dly = 4'h3;
		put(4'h3, 1'b0, 1'b0, BUF + 32'h100, 10'h2, 8'hB0);
		token(PID_OUT, 4'h3, 1'b0, 1'b0, 2, 1'b0);
		chk(rdw(BUF + 32'h100), 32'hA1, "fixed addr");
		chk({rdw(da), wr_cnt}, {c, w + 2}, "retain no wb");
		rreg(REG_FLAGS);
		chk(d, 32'h0, "retain no done");
		mem_dly = 4'h0;
		$display("-- retain done");
		put(4'h4, 1'b1, 1'b1, BUF + 32'h200, 10'h2, 8'h80);
		wrw(BUF + 32'h200, 32'hC35A);
		token(PID_IN, 4'h4, 1'b1, 1'b1, 0, 1'b0);
		chk({txq.size(), txq[1], txq[0]}, {32'd2, 16'hC35A}, "tx");
		chk(rdw(da), wb(2, 0, PID_IN), "in wb");
		chk({DATA1_OUT, TOGGLE_CHECK_OUT}, 2'h0, "par/toggle off");
		put(4'h0, 1'b0, 1'b0, BUF + 32'h300, 10'h1, 8'hC0);
		token(PID_SETUP, 4'h0, 1'b0, 1'b0, 1, 1'b0);
		chk(rdw(da), wb(1, 1, PID_SETUP), "setup wb");
		$display("-- in/setup done");
		wreg(REG_FLAGS, 32'h3);
		put(4'h6, 1'b0, 1'b0, BUF + 32'h400, 10'h1, 8'h80);
		token(PID_OUT, 4'h6, 1'b0, 1'b0, 2, 1'b0);
		chk(hs_code, HS_ACK, "oversize ack");
		chk(rdw(da), wb(1, 0, PID_OUT), "oversize wb");
		chk(rdw(BUF + 32'h400), 32'hA0, "clipped");
		rreg(REG_FLAGS);
		chk(d, 32'h3, "oversize flags");
		wreg(REG_FLAGS, 32'h3);
		iso = 1'b1;
		put(4'hA, 1'b0, 1'b0, BUF + 32'h800, 10'h1, 8'h80);
		token(PID_OUT, 4'hA, 1'b0, 1'b0, 2, 1'b0);
		iso = 1'b0;
		chk(hs_code, 2'bxx, "iso no handshake");
		chk(rdw(da), wb(1, 0, PID_OUT), "iso wb");
		rreg(REG_FLAGS);
		chk(d, 32'h3, "iso flags");
		wreg(REG_FLAGS, 32'h3);
		put(4'h7, 1'b0, 1'b0, BUF + 32'h500, 10'h4, 8'h80);
		token(PID_OUT, 4'h7, 1'b0, 1'b0, 0, 1'b1);
		chk(hs_code, HS_NAK, "late nak");
		chk(rdw(da), c, "late no wb");
		rreg(REG_FLAGS);
		chk({IRQ_OUT, d}, 33'h1_0000_0002, "late flags");
		wreg(REG_EMASK, 32'h0);
		@(negedge CLK_IN);
		chk(IRQ_OUT, 1'b0, "error irq masked");
		wreg(REG_FLAGS, 32'h3);
		$display("-- overrun done");
		wreg(REG_CTRL, 32'h1);
		SIE_RESULT_IN <= PID_ACK;
		put(4'h8, 1'b1, 1'b0, BUF + 32'h600, 10'h1, 8'h80);
		token(PID_OUT, 4'h8, 1'b1, 1'b0, 0, 1'b0);
		chk(rdw(da), wb(1, 0, PID_ACK), "host wb");
		wreg(REG_FLAGS, 32'h3);
		put(4'h9, 1'b0, 1'b0, BUF + 32'h700, 10'h4, 8'h80);
		token(PID_IN, 4'h9, 1'b0, 1'b0, 0, 1'b1);
		chk(hs_code, HS_TMO, "host late");
		chk(rdw(da) & 32'hFC, {PID_LATE, RSV_LO}, "host late pid");
		rreg(REG_FLAGS);
		chk(d, 32'h3, "host late flags");
		$display("-- host done");
		complete_run;
	end
endmodule // usb_buffer_descriptor_dma_tb
